// File: rtl/nsoc_pkg.sv
// Package for the unbalance overcurrent block: map, fields, timing, types
package nsoc_pkg;
  localparam logic [4:0] A_CTRL       = 5'h00;
  localparam logic [4:0] A_TOC_PU     = 5'h01;
  localparam logic [4:0] A_TOC_LIMIT  = 5'h02;
  localparam logic [4:0] A_IOC_PU     = 5'h03;
  localparam logic [4:0] A_IOC_DELAY  = 5'h04;
  localparam logic [4:0] A_V2_FLOOR   = 5'h05;
  localparam logic [4:0] A_DIR_BASE   = 5'h06;
  localparam logic [4:0] A_STATUS     = 5'h14;
  localparam logic [4:0] A_INT_CLR    = 5'h15;
  localparam logic [4:0] A_INT_EN     = 5'h16;
  localparam logic [4:0] N_CFG        = 5'h14;
  localparam int         DIR_STRIDE   = 7;
  localparam int         O_FWD_PU     = 0;
  localparam int         O_REV_PU     = 1;
  localparam int         O_ECA_COS    = 2;
  localparam int         O_ECA_SIN    = 3;
  localparam int         O_FORWARD_LIMIT_ANGLE_COS = 4;
  localparam int         O_REVERSE_LIMIT_ANGLE_COS = 5;
  localparam int         O_ZOFF       = 6;
  localparam int         B_TOC_INST   = 0;
  localparam int         B_IOC_DEF    = 1;
  localparam int         B_DIR_ZERO   = 2;
  localparam int         N_EV         = 6;
  localparam logic [15:0] RST_CFG     = 16'h0000;
  localparam logic [23:0] TOC_DECAY   = 24'h000100;
  localparam int CLK_HZ               = 25_000_000;
  localparam int PS_FREQ_HZ           = 60;
  localparam int EIGHTH_CLKS_DEF      = CLK_HZ / (PS_FREQ_HZ * 8);
  localparam int REV_HOLD_CYC_X100    = 125;
  localparam int FWD_DELAY_CYC_X100   = 150;
  localparam logic [3:0] REV_HOLD_E   = 4'((REV_HOLD_CYC_X100 * 8 + 99) / 100);
  localparam logic [3:0] FWD_DELAY_E  = 4'((FWD_DELAY_CYC_X100 * 8 + 99) / 100);

  typedef struct packed {
    logic [15:0]        i1_mag;
    logic [15:0]        i2_mag;
    logic [15:0]        i0_mag;
    logic [15:0]        v2_mag;
    logic signed [11:0] i2_re;
    logic signed [11:0] i2_im;
    logic signed [11:0] v2_re;
    logic signed [11:0] v2_im;
  } nsoc_meas_s;

  typedef struct packed {
    logic [19:0][15:0]   cfg;
    logic [N_EV-1:0]     status;
    logic [N_EV-1:0]     en;
    logic [N_EV-1:0]     prev;
    logic [15:0]         rdata;
    logic [23:0]         toc_acc;
    logic                toc_trip;
    logic [15:0]         ioc_cnt;
    logic                ioc_pick;
    logic                ioc_out;
    logic [15:0]         div;
    logic                tick;
    logic                irq;
  } nsoc_top_s;

  typedef struct packed {
    logic       fwd;
    logic       rev;
    logic       rev_long;
    logic       dir_f;
    logic       dir_r;
    logic [3:0] rev_cnt;
    logic [3:0] fwd_cnt;
  } nsoc_dir_s;
endpackage

// File: rtl/nsoc_restrain.sv
// Positive-sequence restraint: magnitude minus a fraction of I1, clamped
`timescale 1ns/1ns
`default_nettype none
module nsoc_restrain import nsoc_pkg::*; (
  input  wire logic [15:0] mag,
  input  wire logic [15:0] i1_mag,
  input  wire logic        sixteenth,
  output logic [15:0]      op
);
  logic [15:0] restr;

  always_comb begin
    restr = sixteenth ? (i1_mag >> 4) : (i1_mag >> 3);
    op    = (mag > restr) ? (mag - restr) : 16'h0000;
  end
endmodule
`default_nettype wire

// File: rtl/nsoc_dir_unit.sv
// One directional overcurrent element with current reversal logic
`timescale 1ns/1ns
`default_nettype none
module nsoc_dir_unit import nsoc_pkg::*; (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        tick,
  input  wire logic        meas_valid,
  input  wire nsoc_meas_s  meas,
  input  wire logic        zero_mode,
  input  wire logic [15:0] fwd_pu,
  input  wire logic [15:0] rev_pu,
  input  wire logic [15:0] eca_cos,
  input  wire logic [15:0] eca_sin,
  input  wire logic [15:0] forward_limit_angle_cos,
  input  wire logic [15:0] reverse_limit_angle_cos,
  input  wire logic [15:0] z_offset,
  input  wire logic [15:0] v2_floor,
  output logic             fwd_out,
  output logic             rev_out
);
  nsoc_dir_s          s_ff;
  nsoc_dir_s          nxt_s;
  logic [15:0]        op;
  logic signed [20:0] za_re;
  logic signed [20:0] za_im;
  logic signed [17:0] a_re;
  logic signed [17:0] a_im;
  logic signed [27:0] b_re;
  logic signed [27:0] b_im;
  logic signed [33:0] p_re;
  logic signed [33:0] p_im;
  logic signed [23:0] pr;
  logic signed [23:0] pi;
  logic [48:0]        mag2;
  logic [80:0]        lhs;
  logic [80:0]        rhs_f;
  logic [80:0]        rhs_r;
  logic               v2_ok;
  logic               fwd_raw;
  logic               rev_raw;
  logic               fwd_ok;

  nsoc_restrain u_restr (
    .mag       (zero_mode ? meas.i0_mag : meas.i2_mag),
    .i1_mag    (meas.i1_mag),
    .sixteenth (zero_mode),
    .op        (op)
  );

  always_comb begin
    za_re = $signed({1'b0, z_offset[7:0]}) * meas.i2_re;
    za_im = $signed({1'b0, z_offset[7:0]}) * meas.i2_im;
    a_re  = 18'(za_re >>> 4) - 18'(meas.v2_re);
    a_im  = 18'(za_im >>> 4) - 18'(meas.v2_im);
    b_re  = meas.i2_re * $signed(eca_cos) - meas.i2_im * $signed(eca_sin);
    b_im  = meas.i2_re * $signed(eca_sin) + meas.i2_im * $signed(eca_cos);
    p_re  = a_re * $signed(b_re[27:14]) + a_im * $signed(b_im[27:14]);
    p_im  = a_im * $signed(b_re[27:14]) - a_re * $signed(b_im[27:14]);
    pr    = p_re[33:10];
    pi    = p_im[33:10];
    mag2  = 49'(48'(pr * pr)) + 49'(48'(pi * pi));
    lhs   = 81'(48'(pr * pr)) << 32;
    rhs_f = 81'(forward_limit_angle_cos * forward_limit_angle_cos) * 81'(mag2);
    rhs_r = 81'(reverse_limit_angle_cos * reverse_limit_angle_cos) * 81'(mag2);
    v2_ok = meas.v2_mag > v2_floor;
    fwd_raw = v2_ok && (pr > 0) && (lhs >= rhs_f);
    rev_raw = v2_ok && (pr < 0) && (lhs >= rhs_r);
    fwd_ok  = fwd_raw && (!s_ff.rev_long || s_ff.fwd_cnt == FWD_DELAY_E);
  end

  always_comb begin
    nxt_s = s_ff;
    if (meas_valid) begin
      nxt_s.dir_f = fwd_raw;
      nxt_s.dir_r = rev_raw;
    end
    if (tick) begin
      if (!s_ff.dir_r) begin
        nxt_s.rev_cnt = 4'h0;
      end else if (s_ff.rev_cnt != REV_HOLD_E) begin
        nxt_s.rev_cnt = s_ff.rev_cnt + 4'h1;
      end
      if (!(s_ff.dir_f && s_ff.rev_long)) begin
        nxt_s.fwd_cnt = 4'h0;
      end else if (s_ff.fwd_cnt != FWD_DELAY_E) begin
        nxt_s.fwd_cnt = s_ff.fwd_cnt + 4'h1;
      end
    end
    if (s_ff.rev_cnt == REV_HOLD_E) begin
      nxt_s.rev_long = 1'b1;
    end else if (s_ff.fwd && !s_ff.dir_r) begin
      nxt_s.rev_long = 1'b0;
    end
    if (meas_valid) begin
      nxt_s.fwd = fwd_ok && (op > fwd_pu);
      nxt_s.rev = rev_raw && (op > rev_pu);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign fwd_out = s_ff.fwd;
  assign rev_out = s_ff.rev;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_rev_armed;
    s_ff.rev_long && !fwd_raw;
  endsequence
  sequence s_fwd_try;
    fwd_raw && s_ff.fwd_cnt != FWD_DELAY_E;
  endsequence

  fwd_gate_a: assert property (meas_valid && fwd_ok && op > fwd_pu |=> s_ff.fwd)
    else $error("forward output missed");
  rev_gate_a: assert property (meas_valid |=> s_ff.rev == $past(rev_raw && op > rev_pu))
    else $error("reverse output wrong");
  floor_block_a: assert property (meas_valid && !v2_ok |=> !s_ff.fwd && !s_ff.rev)
    else $error("direction given below voltage floor");
  reversal_hold_a: assert property (s_rev_armed ##1 s_fwd_try |-> !fwd_ok)
    else $error("forward not delayed after reversal");
  mode_op_a: assert property (zero_mode && meas.i0_mag == 16'h0000 |-> op == 16'h0000)
    else $error("zero mode uses wrong current");
  angle_side_a: assert property (fwd_raw |-> !rev_raw)
    else $error("both directions at once");
endmodule
`default_nettype wire

// File: rtl/nsoc_top.sv
// Unbalance overcurrent top: registers, time and instant elements, directional pair
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Instant element operates on I2 magnitude minus one eighth of I1.
// - Directional restraint: I1/8 in negative mode, I1/16 in zero mode.
// - Directional overcurrent uses I2 or I0 magnitude per selected mode.
// - Instant element acts immediately or after a definite delay.
// - Time element resets timed or instantly; blocking resets it the same way.
// - Forward/reverse output needs pickup exceeded and matching direction.
// - Compare offset-compensated negated V2 against I2 rotated by characteristic angle.
// - No direction unless V2 magnitude exceeds the voltage floor.
// - After 1.25 cycles of reverse, delay forward by 1.5 cycles.
// - Direction only within plus or minus limit angle about characteristic angle.
// - Two independent directional elements with own settings and outputs, sharing the V2 floor setting.
// - Reverse characteristic angle is forward angle plus 180 degrees.
module nsoc_top import nsoc_pkg::*; #(
  parameter int unsigned EIGHTH_CLKS = EIGHTH_CLKS_DEF
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  input  wire logic        meas_valid,
  input  wire nsoc_meas_s  meas,
  input  wire logic        toc_block,
  input  wire logic        ioc_block,
  output logic             unbalance_time_element,
  output logic             unbalance_inst_element,
  output logic [1:0]       dir_forward_out,
  output logic [1:0]       dir_reverse_out,
  output logic             irq
);
  nsoc_top_s       s_ff;
  nsoc_top_s       nxt_s;
  logic [15:0]     ioc_op;
  logic [24:0]     toc_sum;
  logic [N_EV-1:0] cur_ev;
  logic [N_EV-1:0] ev;
  logic [N_EV-1:0] clr;
  logic [15:0]     ctrl;
  logic [15:0]     toc_pu;
  logic [15:0]     ioc_pu;

  assign ctrl   = s_ff.cfg[A_CTRL];
  assign toc_pu = s_ff.cfg[A_TOC_PU];
  assign ioc_pu = s_ff.cfg[A_IOC_PU];

  nsoc_restrain u_ioc_restr (
    .mag       (meas.i2_mag),
    .i1_mag    (meas.i1_mag),
    .sixteenth (1'b0),
    .op        (ioc_op)
  );

  for (genvar g = 0; g < 2; g++) begin : g_dir
    localparam int B = int'(A_DIR_BASE) + g * DIR_STRIDE;
    nsoc_dir_unit u_dir (
      .ref_clk    (ref_clk),
      .rst_b      (rst_b),
      .tick       (s_ff.tick),
      .meas_valid (meas_valid),
      .meas       (meas),
      .zero_mode  (ctrl[B_DIR_ZERO + g]),
      .fwd_pu     (s_ff.cfg[B + O_FWD_PU]),
      .rev_pu     (s_ff.cfg[B + O_REV_PU]),
      .eca_cos    (s_ff.cfg[B + O_ECA_COS]),
      .eca_sin    (s_ff.cfg[B + O_ECA_SIN]),
      .forward_limit_angle_cos (s_ff.cfg[B + O_FORWARD_LIMIT_ANGLE_COS]),
      .reverse_limit_angle_cos (s_ff.cfg[B + O_REVERSE_LIMIT_ANGLE_COS]),
      .z_offset   (s_ff.cfg[B + O_ZOFF]),
      .v2_floor   (s_ff.cfg[A_V2_FLOOR]),
      .fwd_out    (dir_forward_out[g]),
      .rev_out    (dir_reverse_out[g])
    );
  end

  always_comb begin
    nxt_s   = s_ff;
    toc_sum = {9'h000, meas.i2_mag} - {9'h000, toc_pu} + {1'b0, s_ff.toc_acc};
    cur_ev  = {dir_reverse_out, dir_forward_out, s_ff.ioc_out, s_ff.toc_trip};
    ev      = cur_ev & ~s_ff.prev;
    clr     = (reg_wr && reg_addr == A_INT_CLR) ? reg_wdata[N_EV-1:0] : '0;

    // Eighth-of-cycle enable
    nxt_s.tick = 1'b0;
    if (s_ff.div >= 16'(EIGHTH_CLKS - 1)) begin
      nxt_s.div  = 16'h0000;
      nxt_s.tick = 1'b1;
    end else begin
      nxt_s.div = s_ff.div + 16'h0001;
    end

    // Register writes and reads
    if (reg_wr && reg_addr < N_CFG) begin
      nxt_s.cfg[reg_addr] = reg_wdata;
    end
    if (reg_wr && reg_addr == A_INT_EN) begin
      nxt_s.en = reg_wdata[N_EV-1:0];
    end
    nxt_s.rdata = 16'h0000;
    if (reg_rd) begin
      if (reg_addr < N_CFG) begin
        nxt_s.rdata = s_ff.cfg[reg_addr];
      end else if (reg_addr == A_STATUS) begin
        nxt_s.rdata = 16'(s_ff.status);
      end else if (reg_addr == A_INT_EN) begin
        nxt_s.rdata = 16'(s_ff.en);
      end
    end

    // Time element
    if (meas_valid) begin
      if (!toc_block && meas.i2_mag > toc_pu) begin
        nxt_s.toc_acc = toc_sum[24] ? 24'hFFFFFF : toc_sum[23:0];
      end else if (ctrl[B_TOC_INST]) begin
        nxt_s.toc_acc = 24'h000000;
      end else if (s_ff.toc_acc >= TOC_DECAY) begin
        nxt_s.toc_acc = s_ff.toc_acc - TOC_DECAY;
      end else begin
        nxt_s.toc_acc = 24'h000000;
      end
      nxt_s.toc_trip = (nxt_s.toc_acc != 24'h000000) &&
                       (nxt_s.toc_acc >= {s_ff.cfg[A_TOC_LIMIT], 8'h00});
    end

    // Instant element
    if (meas_valid) begin
      nxt_s.ioc_pick = !ioc_block && (ioc_op > ioc_pu);
      nxt_s.ioc_out  = nxt_s.ioc_pick &&
                       (!ctrl[B_IOC_DEF] || s_ff.ioc_cnt >= s_ff.cfg[A_IOC_DELAY]);
    end
    if (!nxt_s.ioc_pick) begin
      nxt_s.ioc_cnt = 16'h0000;
    end else if (s_ff.tick && s_ff.ioc_cnt != 16'hFFFF) begin
      nxt_s.ioc_cnt = s_ff.ioc_cnt + 16'h0001;
    end

    // Sticky events, set wins over clear
    nxt_s.prev   = cur_ev;
    nxt_s.status = (s_ff.status & ~clr) | ev;
    nxt_s.irq    = |(nxt_s.status & nxt_s.en);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_ff     <= '0;
      s_ff.cfg <= {20{RST_CFG}};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign reg_rdata              = s_ff.rdata;
  assign unbalance_time_element = s_ff.toc_trip;
  assign unbalance_inst_element = s_ff.ioc_out;
  assign irq                    = s_ff.irq;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  restr_value_a: assert property (meas.i2_mag > (meas.i1_mag >> 3) |->
      ioc_op == meas.i2_mag - (meas.i1_mag >> 3))
    else $error("restrained quantity wrong");
  restr_clamp_a: assert property (meas.i2_mag <= (meas.i1_mag >> 3) |-> ioc_op == 16'h0000)
    else $error("negative quantity not clamped");
  ioc_inst_a: assert property (meas_valid && !ctrl[B_IOC_DEF] && !ioc_block &&
      ioc_op > ioc_pu |=> unbalance_inst_element)
    else $error("instant pickup missed");
  ioc_equal_a: assert property (meas_valid && ioc_op == ioc_pu |=> !unbalance_inst_element)
    else $error("pickup on equality");
  ioc_def_a: assert property ($rose(s_ff.ioc_out) && ctrl[B_IOC_DEF] |->
      $past(s_ff.ioc_cnt) >= $past(s_ff.cfg[A_IOC_DELAY]))
    else $error("definite delay cut short");
  toc_inst_a: assert property (meas_valid && toc_block && ctrl[B_TOC_INST] |=>
      s_ff.toc_acc == 24'h000000 && !unbalance_time_element)
    else $error("blocked accumulator not cleared");
  toc_timed_a: assert property (meas_valid && toc_block && !ctrl[B_TOC_INST] &&
      s_ff.toc_acc >= TOC_DECAY |=> s_ff.toc_acc == $past(s_ff.toc_acc) - TOC_DECAY)
    else $error("timed reset step wrong");
  sticky_set_a: assert property (ev[0] && clr[0] |=> s_ff.status[0] ##1 s_ff.status[0] || clr[0])
    else $error("event lost on clear");
  irq_level_a: assert property (s_ff.status == '0 |=> !irq || $past(ev) != '0)
    else $error("interrupt without status");
  rd_data_a: assert property (reg_rd && reg_addr == A_INT_EN && !reg_wr |=>
      reg_rdata == 16'($past(s_ff.en)))
    else $error("enable readback wrong");
endmodule
`default_nettype wire

// File: tb/nsoc_front_model.sv
// Behavioural sequence phasor front end feeding the unbalance block
`timescale 1ns/1ns
`default_nettype none
module nsoc_front_model import nsoc_pkg::*; (
  input  wire logic     ref_clk,
  output var logic      meas_valid,
  output var nsoc_meas_s meas
);
  initial begin
    meas_valid = 1'b0;
    meas       = '1;
  end
  // One pass per cycle for n cycles, then the complement of the pass on the bus
  task automatic send(input nsoc_meas_s m, input int n);
    @(posedge ref_clk);
    meas_valid <= 1'b1;
    meas       <= m;
    repeat (n) @(posedge ref_clk);
    meas_valid <= 1'b0;
    meas       <= ~m;
  endtask
endmodule
`default_nettype wire

// File: tb/nsoc_top_tb.sv
// Self-checking bench for the unbalance overcurrent block
`timescale 1ns/1ns
`default_nettype none
module nsoc_top_tb import nsoc_pkg::*; ();
  localparam int               EC  = 4;
  localparam logic signed [11:0] NG = 12'shF00;
  localparam logic signed [11:0] PS = 12'sh100;
  localparam logic signed [11:0] ZR = 12'sh000;
  logic        ref_clk;
  logic        rst_b;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        meas_valid;
  nsoc_meas_s  meas;
  logic        toc_block;
  logic        ioc_block;
  logic        toc_out;
  logic        ioc_out;
  logic [1:0]  fwd;
  logic [1:0]  rev;
  logic        irq;
  int          n_mismatch;
  int          tests_run;
  int          cyc;

  nsoc_front_model fm (.ref_clk(ref_clk), .meas_valid(meas_valid), .meas(meas));
  nsoc_top #(.EIGHTH_CLKS(EC)) uut (
    .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_valid(meas_valid),
    .meas(meas), .toc_block(toc_block), .ioc_block(ioc_block),
    .unbalance_time_element(toc_out), .unbalance_inst_element(ioc_out),
    .dir_forward_out(fwd), .dir_reverse_out(rev), .irq(irq));

  always #20 ref_clk = ~ref_clk;

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    @(negedge ref_clk);
    chk(reg_rdata, exp);
  endtask

  function automatic nsoc_meas_s mk(input logic [15:0] i1, i2, i0, v2,
                                    input logic signed [11:0] vr, vi);
    mk = '{i1, i2, i0, v2, PS, ZR, vr, vi};
  endfunction

  task automatic pass(input nsoc_meas_s m, input int n);
    fm.send(m, n);
    @(negedge ref_clk);
  endtask

  // Blocked pass of the time element
  task automatic bpass(input nsoc_meas_s m);
    @(posedge ref_clk);
    toc_block <= 1'b1;
    pass(m, 1);
    @(posedge ref_clk);
    toc_block <= 1'b0;
  endtask

  task automatic dcfg(input int k, input logic [15:0] pu);
    logic [4:0] b;
    b = 5'(A_DIR_BASE + 5'(k * DIR_STRIDE));
    wr(b + 5'(O_FWD_PU), pu);
    wr(b + 5'(O_REV_PU), pu);
    wr(b + 5'(O_ECA_COS), 16'h4000);
    wr(b + 5'(O_FORWARD_LIMIT_ANGLE_COS), 16'h8000);
    wr(b + 5'(O_REVERSE_LIMIT_ANGLE_COS), 16'h8000);
  endtask

  task automatic t_regs();
    rd(A_CTRL, 16'h0000);
    rd(A_STATUS, 16'h0000);
    wr(A_INT_EN, 16'h003F);
    rd(A_INT_EN, 16'h003F);
    wr(A_STATUS, 16'h003F);
    rd(A_STATUS, 16'h0000);
    rd(A_INT_CLR, 16'h0000);
    rd(5'h1F, 16'h0000);
    wr(A_INT_EN, 16'h0000);
    $display("regs done");
  endtask

  task automatic t_irq();
    wr(A_IOC_PU, 16'h0020);
    pass(mk(16'h0080, 16'h0031, 16'h0000, 16'h0000, ZR, ZR), 1);
    chk(16'(ioc_out), 16'h0001);
    repeat (3) @(negedge ref_clk);
    chk(16'(irq), 16'h0000);
    rd(A_STATUS, 16'h0003);
    wr(A_INT_EN, 16'h0002);
    repeat (2) @(negedge ref_clk);
    chk(16'(irq), 16'h0001);
    wr(A_INT_CLR, 16'h0002);
    repeat (2) @(negedge ref_clk);
    chk(16'(irq), 16'h0000);
    rd(A_STATUS, 16'h0001);
    $display("irq done");
  endtask

  task automatic t_ioc();
    pass(mk(16'h0080, 16'h0030, 16'h0000, 16'h0000, ZR, ZR), 1);
    chk(16'(ioc_out), 16'h0000);
    pass(mk(16'h0080, 16'h0031, 16'h0000, 16'h0000, ZR, ZR), 1);
    chk(16'(ioc_out), 16'h0001);
    wr(A_IOC_PU, 16'h0000);
    pass(mk(16'hFFF0, 16'h0010, 16'h0000, 16'h0000, ZR, ZR), 1);
    chk(16'(ioc_out), 16'h0000);
    wr(A_CTRL, 16'h0002);
    wr(A_IOC_DELAY, 16'h0002);
    wr(A_IOC_PU, 16'h0020);
    pass(mk(16'h0000, 16'h0010, 16'h0000, 16'h0000, ZR, ZR), 1);
    pass(mk(16'h0000, 16'h0031, 16'h0000, 16'h0000, ZR, ZR), 1);
    chk(16'(ioc_out), 16'h0000);
    pass(mk(16'h0000, 16'h0031, 16'h0000, 16'h0000, ZR, ZR), 16);
    chk(16'(ioc_out), 16'h0001);
    $display("inst done");
  endtask

  task automatic t_toc();
    nsoc_meas_s m;
    m = mk(16'h0000, 16'h0190, 16'h0000, 16'h0000, ZR, ZR);
    wr(A_CTRL, 16'h0001);
    wr(A_TOC_PU, 16'h0010);
    wr(A_TOC_LIMIT, 16'h0002);
    bpass(m);
    pass(m, 1);
    bpass(m);
    pass(m, 1);
    chk(16'(toc_out), 16'h0000);
    bpass(m);
    wr(A_CTRL, 16'h0000);
    pass(m, 1);
    bpass(m);
    pass(m, 1);
    chk(16'(toc_out), 16'h0001);
    $display("time done");
  endtask

  task automatic t_dir();
    nsoc_meas_s mf;
    nsoc_meas_s mr;
    mf = mk(16'h0000, 16'h0100, 16'h0000, 16'h0100, NG, ZR);
    mr = mk(16'h0000, 16'h0100, 16'h0000, 16'h0100, PS, ZR);
    wr(A_V2_FLOOR, 16'h0010);
    dcfg(0, 16'h0010);
    dcfg(1, 16'hFFFF);
    pass(mf, 1);
    chk(16'({fwd, rev}), 16'h0004);
    pass(mr, 1);
    chk(16'({fwd, rev}), 16'h0001);
    pass(mk(16'h0000, 16'h0100, 16'h0000, 16'h0010, NG, ZR), 1);
    chk(16'({fwd, rev}), 16'h0000);
    pass(mk(16'h0000, 16'h0100, 16'h0000, 16'h0100, ZR, NG), 1);
    chk(16'({fwd, rev}), 16'h0000);
    pass(mk(16'h0100, 16'h0030, 16'h0000, 16'h0100, NG, ZR), 1);
    chk(16'(fwd), 16'h0000);
    pass(mk(16'h0100, 16'h0031, 16'h0000, 16'h0100, NG, ZR), 1);
    chk(16'(fwd), 16'h0001);
    wr(A_CTRL, 16'h0004);
    pass(mk(16'h0100, 16'h0000, 16'h0020, 16'h0100, NG, ZR), 1);
    chk(16'(fwd), 16'h0000);
    pass(mk(16'h0100, 16'h0000, 16'h0021, 16'h0100, NG, ZR), 1);
    chk(16'(fwd), 16'h0001);
    wr(A_CTRL, 16'h0000);
    dcfg(1, 16'h0010);
    pass(mf, 1);
    chk(16'(fwd), 16'h0003);
    fm.send(mr, 60);
    pass(mf, 40);
    chk(16'(fwd), 16'h0000);
    pass(mf, 24);
    chk(16'(fwd), 16'h0003);
    $display("dir done");
  endtask

  initial begin
    ref_clk    = 1'b0;
    rst_b      = 1'b0;
    reg_addr   = 5'h00;
    reg_wdata  = 16'h0000;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    toc_block  = 1'b0;
    ioc_block  = 1'b0;
    n_mismatch = 0;
    tests_run  = 0;
    cyc        = 0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_regs();
    t_irq();
    t_ioc();
    t_toc();
    t_dir();
    end_sim();
  end
endmodule
`default_nettype wire
